/* design/tcc_top.sv */
// two-channel capture/compare/pwm timer with its counter and AHB-Lite register slave
//
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
//Behaviour
// (R1) capture loads 16-bit value into two bytes
// (R2) edge select bits choose capture polarity
// (R3) captured value is counter plus two
// (R4) every qualifying edge overwrites the value
// (R5) capture flag requests interrupt when enabled
// (R6) reset leaves value registers untouched
// (R7) compare match sets, clears or toggles pin
// (R8) compare match sets flag, interrupt if enabled
// (R9) unbuffered value write takes effect directly
// (R10) software writes smaller values from compare interrupt
// (R11) buffered select links channels onto pin zero
// (R12) last written channel controls after overflow
// (R13) linked pair uses channel zero control only
// (R14) software writes only the inactive channel
// (R15) toggle on overflow at modulo rollover
// (R16) pulse width is overflow to compare match
// (R17) modulo 255 undivided gives 256-cycle period
// (R18) value 128 gives half duty cycle
// (R19) software picks clear or set per level
// (R20) software avoids toggle on compare for pwm
// (R21) mode encoding, buffered bit has priority
// (R22) no overflow toggle zero duty, max full
// (R23) counter clocked from seven prescaled rates
// (R24) match on counter value equal once per period
// (R25) pin passes two stages before edge detect
module tcc_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic chan0_pin_in,
    output logic chan0_pin_out,
    output logic chan0_pin_oe,
    input wire logic chan1_pin_in,
    output logic chan1_pin_out,
    output logic chan1_pin_oe,
    output logic chan0_irq,
    output logic chan1_irq,
    output logic overflow_irq
);
    import tcc_pkg::*;

    tcc_chan_if cif[2] ();

    // ==========================================================
    // bus address phase capture
    logic a_valid;
    logic a_write;
    logic [7:0] a_index;
    logic next_a_valid;
    logic next_a_write;
    logic [7:0] next_a_index;
    logic addr_ok;
    logic wr_now;
    logic rd_now;
    logic [7:0] wbyte;

    always_comb begin
        // only whole aligned words inside the low window are mapped
        addr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
        next_a_valid = hsel && hready && htrans[1] && addr_ok;
        next_a_write = hwrite;
        next_a_index = haddr[9:2];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_index <= 8'h00;
        end else begin
            a_valid <= next_a_valid;
            a_write <= next_a_write;
            a_index <= next_a_index;
        end
    end

    assign wr_now = a_valid && a_write;
    assign rd_now = a_valid && !a_write;
    assign wbyte = hwdata[7:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ==========================================================
    // timer control, prescaler and counter
    logic [2:0] ps;
    logic stop;
    logic toie;
    logic tof;
    logic tof_armed;
    logic [PRESCALE_WIDTH-1:0] presc;
    logic [15:0] count;
    logic [15:0] modulo;
    logic cnt_upd;
    logic ovf;
    logic [2:0] next_ps;
    logic next_stop;
    logic next_toie;
    logic next_tof;
    logic next_tof_armed;
    logic [PRESCALE_WIDTH-1:0] next_presc;
    logic [15:0] next_count;
    logic [15:0] next_modulo;
    logic next_cnt_upd;
    logic next_ovf;
    logic tick;
    logic roll;
    logic wr_tctrl;

    always_comb begin
        wr_tctrl = wr_now && (a_index == IDX_TIMER_CTRL);
        next_ps = ps;
        next_stop = stop;
        next_toie = toie;
        next_tof = tof;
        next_tof_armed = tof_armed;
        next_modulo = modulo;
        next_presc = presc;
        next_count = count;
        tick = 1'b0;
        roll = 1'b0;
        if (wr_tctrl) begin
            next_ps = wbyte[TCTRL_PS_LSB +: 3];
            next_stop = wbyte[TCTRL_STOP_BIT];
            next_toie = wbyte[TCTRL_IE_BIT];
        end
        if (wr_now && (a_index == IDX_MOD_HIGH)) begin
            next_modulo[15:8] = wbyte;
        end
        if (wr_now && (a_index == IDX_MOD_LOW)) begin
            next_modulo[7:0] = wbyte;
        end
        if (!stop) begin
            // divide by 1, 2, 4 .. 64
            tick = ((presc & tcc_div_mask(ps)) == tcc_div_mask(ps)); // (R23)
            next_presc = presc + PRESCALE_WIDTH'(1);
            if (tick) begin
                next_presc = '0;
                roll = (count == modulo);
                next_count = roll ? 16'h0000 : count + 16'h0001; // (R17)
            end
        end
        if (wr_tctrl && wbyte[TCTRL_RESET_BIT]) begin
            next_presc = '0;
            next_count = 16'h0000;
            tick = 1'b0;
            roll = 1'b0;
        end
        if (rd_now && (a_index == IDX_TIMER_CTRL) && tof) begin
            next_tof_armed = 1'b1;
        end
        if (wr_tctrl && !wbyte[TCTRL_FLAG_BIT] && tof_armed) begin
            next_tof = 1'b0;
            next_tof_armed = 1'b0;
        end
        if (roll) begin
            next_tof = 1'b1;
            next_tof_armed = 1'b0;
        end
        next_cnt_upd = tick;
        next_ovf = roll;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps <= TCTRL_RESET[TCTRL_PS_LSB +: 3];
            stop <= TCTRL_RESET[TCTRL_STOP_BIT];
            toie <= TCTRL_RESET[TCTRL_IE_BIT];
            tof <= TCTRL_RESET[TCTRL_FLAG_BIT];
            tof_armed <= 1'b0;
            presc <= '0;
            count <= 16'h0000;
            modulo <= MOD_RESET;
            cnt_upd <= 1'b0;
            ovf <= 1'b0;
        end else begin
            ps <= next_ps;
            stop <= next_stop;
            toie <= next_toie;
            tof <= next_tof;
            tof_armed <= next_tof_armed;
            presc <= next_presc;
            count <= next_count;
            modulo <= next_modulo;
            cnt_upd <= next_cnt_upd;
            ovf <= next_ovf;
        end
    end

    // ==========================================================
    // channel linking for buffered operation
    logic linked;
    logic active_sel;
    logic written_last;
    logic next_active_sel;
    logic next_written_last;
    logic wr_val0;
    logic wr_val1;

    always_comb begin
        linked = cif[0].ctrl[CCTRL_MSB_BIT]; // (R11) (R21)
        wr_val0 = wr_now && ((a_index == IDX_CHAN0_HIGH) || (a_index == IDX_CHAN0_LOW));
        wr_val1 = wr_now && ((a_index == IDX_CHAN1_HIGH) || (a_index == IDX_CHAN1_LOW));
        next_active_sel = active_sel;
        next_written_last = written_last;
        if (!linked) begin
            // channel 0 always starts in control once linking begins
            next_active_sel = 1'b0;
            next_written_last = 1'b0;
        end else begin
            if (wr_val1) begin
                next_written_last = 1'b1;
            end else if (wr_val0) begin
                next_written_last = 1'b0;
            end
            if (ovf) begin
                next_active_sel = written_last; // (R12)
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_sel <= 1'b0;
            written_last <= 1'b0;
        end else begin
            active_sel <= next_active_sel;
            written_last <= next_written_last;
        end
    end

    // ==========================================================
    // channel instances
    logic [1:0] pin_in_bus;

    assign pin_in_bus = {chan1_pin_in, chan0_pin_in};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            localparam logic [7:0] BASE = IDX_CHAN0_CTRL + 8'(i) * IDX_CHAN_STRIDE;
            assign cif[i].wr_ctrl = wr_now && (a_index == BASE);
            assign cif[i].wr_high = wr_now && (a_index == BASE + 8'h01);
            assign cif[i].wr_low = wr_now && (a_index == BASE + 8'h02);
            assign cif[i].rd_ctrl = rd_now && (a_index == BASE);
            assign cif[i].wdata = wbyte;
            assign cif[i].count = count;
            assign cif[i].cnt_upd = cnt_upd;
            assign cif[i].ovf = ovf;
            assign cif[i].pin_in = pin_in_bus[i];
            tcc_chan #(
                .LINK_MASTER(i == 0)
            ) u_chan (
                .hclk(hclk),
                .hresetn(hresetn),
                .cif(cif[i])
            );
        end
    endgenerate

    assign cif[0].suspend = 1'b0;
    assign cif[1].suspend = linked; // (R13)
    assign cif[0].cmp_value = (linked && active_sel) ? cif[1].value : cif[0].value; // (R11) (R12)
    assign cif[1].cmp_value = cif[1].value;

    assign chan0_pin_out = cif[0].pin_out;
    assign chan0_pin_oe = cif[0].pin_oe;
    assign chan1_pin_out = cif[1].pin_out;
    assign chan1_pin_oe = cif[1].pin_oe;
    assign chan0_irq = cif[0].irq;
    assign chan1_irq = cif[1].irq;
    assign overflow_irq = tof && toie;

    // ==========================================================
    // read mux over registered index, valid in the data phase
    always_comb begin
        hrdata = 32'h00000000;
        if (rd_now) begin
            case (a_index)
                IDX_TIMER_CTRL: hrdata[7:0] = {tof, toie, stop, 2'h0, ps};
                IDX_COUNT_HIGH: hrdata[7:0] = count[15:8];
                IDX_COUNT_LOW: hrdata[7:0] = count[7:0];
                IDX_MOD_HIGH: hrdata[7:0] = modulo[15:8];
                IDX_MOD_LOW: hrdata[7:0] = modulo[7:0];
                IDX_CHAN0_CTRL: hrdata[7:0] = cif[0].ctrl;
                IDX_CHAN0_HIGH: hrdata[7:0] = cif[0].value[15:8];
                IDX_CHAN0_LOW: hrdata[7:0] = cif[0].value[7:0];
                IDX_CHAN1_CTRL: hrdata[7:0] = cif[1].ctrl;
                IDX_CHAN1_HIGH: hrdata[7:0] = cif[1].value[15:8];
                IDX_CHAN1_LOW: hrdata[7:0] = cif[1].value[7:0];
                default: hrdata = 32'h00000000;
            endcase
        end
    end
endmodule

/* design/tcc_pkg.sv */
// shared constants, types and decode functions of the two-channel capture/compare timer
package tcc_pkg;

    // ==========================================================
    // clock and timing
    localparam int HCLK_PERIOD_NS = 10;
    localparam logic [15:0] CAPTURE_OFFSET = 16'h0002;
    localparam int PRESCALE_WIDTH = 6;
    localparam logic [2:0] PS_MAX_SEL = 3'h6;

    // ==========================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h51;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'h52;
    localparam logic [7:0] IDX_COUNT_LOW = 8'h53;
    localparam logic [7:0] IDX_MOD_HIGH = 8'h54;
    localparam logic [7:0] IDX_MOD_LOW = 8'h55;
    localparam logic [7:0] IDX_CHAN0_CTRL = 8'h56;
    localparam logic [7:0] IDX_CHAN0_HIGH = 8'h57;
    localparam logic [7:0] IDX_CHAN0_LOW = 8'h58;
    localparam logic [7:0] IDX_CHAN1_CTRL = 8'h59;
    localparam logic [7:0] IDX_CHAN1_HIGH = 8'h5A;
    localparam logic [7:0] IDX_CHAN1_LOW = 8'h5B;
    localparam logic [7:0] IDX_CHAN_STRIDE = 8'h03;

    // ==========================================================
    // timer control fields
    localparam int TCTRL_FLAG_BIT = 7;
    localparam int TCTRL_IE_BIT = 6;
    localparam int TCTRL_STOP_BIT = 5;
    localparam int TCTRL_RESET_BIT = 4;
    localparam int TCTRL_PS_LSB = 0;
    localparam logic [7:0] TCTRL_RESET = 8'h20;
    localparam logic [15:0] MOD_RESET = 16'hFFFF;

    // ==========================================================
    // channel control fields
    localparam int CCTRL_FLAG_BIT = 7;
    localparam int CCTRL_IE_BIT = 6;
    localparam int CCTRL_MSB_BIT = 5;
    localparam int CCTRL_MSA_BIT = 4;
    localparam int CCTRL_ELSB_BIT = 3;
    localparam int CCTRL_ELSA_BIT = 2;
    localparam int CCTRL_TOV_BIT = 1;
    localparam int CCTRL_MAX_BIT = 0;
    localparam logic [7:0] CCTRL_RESET = 8'h00;

    typedef enum logic [1:0] {
        TCC_MODE_CAPTURE = 2'h0,
        TCC_MODE_COMPARE = 2'h1,
        TCC_MODE_BUFFERED = 2'h3
    } tcc_mode_type;

    // buffered select outranks the other mode bit
    function automatic tcc_mode_type tcc_mode(input logic msb, input logic msa);
        if (msb) begin
            return TCC_MODE_BUFFERED;
        end
        return msa ? TCC_MODE_COMPARE : TCC_MODE_CAPTURE;
    endfunction

    // prescaler mask: divide by two to the power of the select, top select reused
    function automatic logic [PRESCALE_WIDTH-1:0] tcc_div_mask(input logic [2:0] ps);
        logic [2:0] sel;
        sel = (ps > PS_MAX_SEL) ? PS_MAX_SEL : ps;
        return PRESCALE_WIDTH'((7'h01 << sel) - 7'h01);
    endfunction

endpackage

/* design/tcc_chan_if.sv */
// carrier between the timer core and one channel
`timescale 1ns/1ps
interface tcc_chan_if;
    logic wr_ctrl;
    logic wr_high;
    logic wr_low;
    logic rd_ctrl;
    logic [7:0] wdata;
    logic [15:0] count;
    logic cnt_upd;
    logic ovf;
    logic suspend;
    logic pin_in;
    logic [15:0] cmp_value;
    logic [7:0] ctrl;
    logic [15:0] value;
    logic pin_out;
    logic pin_oe;
    logic irq;

    modport timer (
        output wr_ctrl, wr_high, wr_low, rd_ctrl, wdata, count, cnt_upd, ovf, suspend, pin_in, cmp_value,
        input ctrl, value, pin_out, pin_oe, irq
    );
    modport chan (
        input wr_ctrl, wr_high, wr_low, rd_ctrl, wdata, count, cnt_upd, ovf, suspend, pin_in, cmp_value,
        output ctrl, value, pin_out, pin_oe, irq
    );
endinterface

/* design/tcc_chan.sv */
// one capture/compare/pwm channel
`timescale 1ns/1ps
module tcc_chan #(
    parameter bit LINK_MASTER = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    tcc_chan_if.chan cif
);
    import tcc_pkg::*;

    logic [6:0] cfg;
    logic flag;
    logic armed;
    logic [15:0] val;
    logic sync1, sync2, sync3;
    logic pin_q;
    logic [6:0] next_cfg;
    logic next_flag;
    logic next_armed;
    logic [15:0] next_val;
    logic next_pin;
    tcc_mode_type mode;
    logic capturing, comparing, edge_hit, match, evt, clear_req;

    // ==========================================================
    // event detection
    always_comb begin
        mode = tcc_mode(cfg[CCTRL_MSB_BIT], cfg[CCTRL_MSA_BIT]);
        capturing = !cif.suspend && (mode == TCC_MODE_CAPTURE);
        comparing = !cif.suspend && (mode != TCC_MODE_CAPTURE);
        // 01 rising, 10 falling, 11 either
        edge_hit = capturing && ((cfg[CCTRL_ELSA_BIT] && sync2 && !sync3) || // (R2) (R25)
                                 (cfg[CCTRL_ELSB_BIT] && !sync2 && sync3));
        match = comparing && cif.cnt_upd && (cif.count == cif.cmp_value); // (R24) (R18)
        evt = edge_hit || match; // (R8)
        clear_req = cif.wr_ctrl && !cif.wdata[CCTRL_FLAG_BIT] && armed;
    end

    // ==========================================================
    // control and flag
    always_comb begin
        next_cfg = cfg;
        next_flag = flag;
        next_armed = armed;
        if (cif.wr_ctrl) begin
            next_cfg = cif.wdata[6:0];
            if (!LINK_MASTER) begin
                next_cfg[CCTRL_MSB_BIT] = 1'b0;
            end
        end
        if (cif.rd_ctrl && flag) begin
            next_armed = 1'b1;
        end
        if (clear_req) begin
            next_flag = 1'b0;
            next_armed = 1'b0;
        end
        // a new event outranks a clear in the same cycle
        if (evt) begin
            next_flag = 1'b1;
            next_armed = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= CCTRL_RESET[6:0];
            flag <= 1'b0;
            armed <= 1'b0;
        end else begin
            cfg <= next_cfg;
            flag <= next_flag;
            armed <= next_armed;
        end
    end

    // ==========================================================
    // value register, left alone by reset
    always_comb begin
        next_val = val;
        if (cif.wr_high) begin
            next_val[15:8] = cif.wdata; // (R9)
        end
        if (cif.wr_low) begin
            next_val[7:0] = cif.wdata; // (R9)
        end
        if (edge_hit) begin
            next_val = cif.count + CAPTURE_OFFSET; // (R1) (R3) (R4)
        end
    end

    always_ff @(posedge hclk) begin
        val <= next_val; // (R6)
    end

    // ==========================================================
    // pin synchroniser and output
    always_comb begin
        next_pin = pin_q;
        if (comparing && cif.ovf && cfg[CCTRL_TOV_BIT]) begin
            next_pin = !pin_q; // (R15) (R16)
        end
        if (match) begin
            case ({cfg[CCTRL_ELSB_BIT], cfg[CCTRL_ELSA_BIT]}) // (R7)
                2'h1: next_pin = !pin_q;
                2'h2: next_pin = 1'b0;
                2'h3: next_pin = 1'b1;
                default: next_pin = next_pin;
            endcase
        end
        if (comparing && cfg[CCTRL_MAX_BIT] && !cfg[CCTRL_TOV_BIT]) begin
            next_pin = 1'b1; // (R22)
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
            pin_q <= 1'b0;
        end else begin
            sync1 <= cif.pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            pin_q <= next_pin;
        end
    end

    assign cif.ctrl = {flag, cfg};
    assign cif.value = val;
    assign cif.pin_out = pin_q;
    // a suspended channel leaves its pin to general-purpose use
    assign cif.pin_oe = comparing && (cfg[CCTRL_ELSB_BIT] || cfg[CCTRL_ELSA_BIT]); // (R13)
    assign cif.irq = flag && cfg[CCTRL_IE_BIT]; // (R5) (R8)
endmodule

/* test/tcc_pin_model.sv */
// pin-side model of one timer channel pin
`timescale 1ns/1ps
module tcc_pin_model (
    input wire logic level,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    // ==========
    // wire level
    // the outside level only shows while the timer leaves the pin undriven
    assign pin_in = pin_oe ? pin_out : level;
endmodule

/* test/tcc_assertions.sv */
// concurrent checks on the ports of the capture/compare timer
`timescale 1ns/1ps
module tcc_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic chan0_irq
);
    import tcc_pkg::*;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ==========
    // bus phases
    sequence read_addr;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence write_done;
        $past(hsel && hready && htrans[1] && hwrite, 2);
    endsequence
    // ==========
    // checks
    chk_ready_always: assert property (hreadyout == 1'b1) else $error("hreadyout low");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    chk_rdata_upper: assert property (read_addr |=> hrdata[31:8] == 24'h0) else $error("upper read bits set");
    chk_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("hrdata outside read phase");
    chk_unmapped_zero: assert property (read_addr ##0 haddr[31:10] != 22'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_tctrl_rst_bit: assert property (read_addr ##0 haddr[9:2] == IDX_TIMER_CTRL |=> !hrdata[TCTRL_RESET_BIT])
        else $error("counter reset bit reads one");
    chk_ch1_link_bit: assert property (read_addr ##0 haddr[9:2] == IDX_CHAN1_CTRL |=> !hrdata[CCTRL_MSB_BIT])
        else $error("channel 1 link bit reads one");
    // a raised request only drops after software touched a register
    chk_irq_hold: assert property ($fell(chan0_irq) |-> write_done) else $error("irq dropped on its own");
endmodule

bind tcc_top tcc_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan0_irq(chan0_irq));

/* test/testbench.sv */
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module testbench;
    import tcc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [21:0] page = 22'h0;
    logic pin0_level = 1'b0;
    logic pin1_level = 1'b0;
    logic hreadyout, hresp, chan0_pin_in, chan0_pin_out, chan0_pin_oe;
    logic chan1_pin_in, chan1_pin_out, chan1_pin_oe, chan0_irq, chan1_irq, overflow_irq;
    logic [31:0] hrdata, hrdata_q;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;

    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        hrdata_q <= hrdata;
        cyc <= cyc + 1;
    end

    tcc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .chan0_pin_in, .chan0_pin_out, .chan0_pin_oe, .chan1_pin_in,
        .chan1_pin_out, .chan1_pin_oe, .chan0_irq, .chan1_irq, .overflow_irq);
    tcc_pin_model pin0 (.level(pin0_level), .pin_out(chan0_pin_out), .pin_oe(chan0_pin_oe), .pin_in(chan0_pin_in));
    tcc_pin_model pin1 (.level(pin1_level), .pin_out(chan1_pin_out), .pin_oe(chan1_pin_oe), .pin_in(chan1_pin_in));

    // ==========
    // bus and compare tasks
    task automatic wait_ready;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rdv);
        @(posedge hclk);
        haddr <= {page, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        #1;
        rdv = hrdata_q[7:0];
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        bus(1'b0, idx, 8'h00, d);
    endtask
    task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
        wr(idx, v[15:8]);
        wr(idx + 8'h01, v[7:0]);
    endtask
    task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
        rd(idx, v[15:8]);
        rd(idx + 8'h01, v[7:0]);
    endtask
    task automatic check_num(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_bit(input string n, input logic e, input logic g);
        check_num(n, {15'h0, e}, {15'h0, g});
    endtask
    // window of 512 cycles: whole periods of 256, so counts do not depend on phase
    task automatic measure(output int high, output int rises);
        logic prev;
        repeat (600) @(posedge hclk);
        #1;
        prev = chan0_pin_out;
        high = 0;
        rises = 0;
        repeat (512) begin
            @(posedge hclk);
            #1;
            high += int'(chan0_pin_out === 1'b1);
            rises += int'(prev === 1'b0 && chan0_pin_out === 1'b1);
            prev = chan0_pin_out;
        end
    endtask

    // ==========
    // scenarios
    task automatic test_reset_values;
        logic [7:0] d;
        rd(IDX_TIMER_CTRL, d);
        check_num("tctrl reset", {8'h0, TCTRL_RESET}, {8'h0, d});
        rd(IDX_MOD_HIGH, d);
        check_num("mod high reset", 16'h00FF, {8'h0, d});
        rd(IDX_CHAN0_CTRL, d);
        check_num("ch0 ctrl reset", {8'h0, CCTRL_RESET}, {8'h0, d});
        page = 22'h1;
        rd(IDX_TIMER_CTRL, d);
        page = 22'h0;
        check_num("unmapped read", 16'h0000, {8'h0, d});
    endtask
    task automatic test_capture;
        logic [7:0] d;
        logic [15:0] v1, v2;
        int c1, c2;
        wr(IDX_TIMER_CTRL, 8'h00);
        wr(IDX_CHAN0_CTRL, 8'h44);
        wr(IDX_CHAN1_CTRL, 8'h08);
        @(posedge hclk);
        pin0_level <= 1'b1;
        pin1_level <= 1'b1;
        c1 = cyc;
        repeat (10) @(posedge hclk);
        check_bit("chan0_irq", 1'b1, chan0_irq);
        check_bit("chan1_irq", 1'b0, chan1_irq);
        rd(IDX_CHAN1_CTRL, d);
        check_bit("ch1 flag on rise", 1'b0, d[7]);
        rd16(IDX_CHAN0_HIGH, v1);
        @(posedge hclk);
        pin0_level <= 1'b0;
        pin1_level <= 1'b0;
        repeat (40) @(posedge hclk);
        pin0_level <= 1'b1;
        c2 = cyc;
        repeat (10) @(posedge hclk);
        rd(IDX_CHAN1_CTRL, d);
        check_bit("ch1 flag on fall", 1'b1, d[7]);
        rd16(IDX_CHAN0_HIGH, v2);
        check_num("capture span", 16'(c2 - c1), v2 - v1);
    endtask
    task automatic test_compare;
        logic [7:0] ctl [5] = '{8'h1A, 8'h19, 8'h18, 8'h1C, 8'h14};
        int exp_high [5] = '{256, 512, 0, 512, 256};
        int exp_rise [5] = '{2, 0, 0, 0, 1};
        logic [7:0] d;
        int high, rises;
        wr(IDX_MOD_HIGH, 8'h00);
        wr(IDX_MOD_LOW, 8'hFF);
        wr16(IDX_CHAN0_HIGH, 16'h0080);
        wr(IDX_TIMER_CTRL, 8'h10);
        for (int i = 0; i < 5; i++) begin
            rd(IDX_CHAN0_CTRL, d);
            wr(IDX_CHAN0_CTRL, ctl[i]);
            measure(high, rises);
            check_num("pin high cycles", 16'(exp_high[i]), 16'(high));
            check_num("pin rises", 16'(exp_rise[i]), 16'(rises));
            rd(IDX_CHAN0_CTRL, d);
            check_bit("ch0 match flag", 1'b1, d[7]);
        end
    endtask
    task automatic test_linked;
        int high, rises;
        wr(IDX_CHAN1_CTRL, 8'h1A);
        @(posedge hclk);
        #1;
        check_bit("ch1 oe unlinked", 1'b1, chan1_pin_oe);
        wr16(IDX_CHAN0_HIGH, 16'h0040);
        wr(IDX_CHAN0_CTRL, 8'h2A);
        measure(high, rises);
        check_num("linked ch0 width", 16'd128, 16'(high));
        check_bit("ch1 oe linked", 1'b0, chan1_pin_oe);
        wr16(IDX_CHAN1_HIGH, 16'h00C0);
        measure(high, rises);
        check_num("linked ch1 width", 16'd384, 16'(high));
        wr16(IDX_CHAN0_HIGH, 16'h0020);
        measure(high, rises);
        check_num("linked back ch0", 16'd64, 16'(high));
    endtask
    // bus calls are three cycles apart, so two low-byte reads are six cycles apart
    task automatic test_prescale;
        logic [15:0] a, b;
        rd(IDX_TIMER_CTRL, a[7:0]);
        wr(IDX_TIMER_CTRL, 8'h51);
        rd16(IDX_COUNT_HIGH, a);
        rd16(IDX_COUNT_HIGH, b);
        check_num("count at half rate", 16'h0003, b - a);
        #1;
        check_bit("overflow_irq cleared", 1'b0, overflow_irq);
        repeat (600) @(posedge hclk);
        #1;
        check_bit("overflow_irq", 1'b1, overflow_irq);
    endtask

    // ==========
    // run control
    task automatic report_and_stop;
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_values();
        test_capture();
        test_compare();
        test_linked();
        test_prescale();
        report_and_stop();
    end
    // whole run is about 10k cycles; three times that means a hang
    initial begin
        repeat (30000) @(posedge hclk);
        bad_count++;
        report_and_stop();
    end
endmodule
